// >>> dv/rst_pin_model.sv
// Reset pin wire with its pull-up and an outside party that may pull it low.
`timescale 1ns/1ps
module rst_pin_model (
    // Device pin driver.
    input  wire logic drv_i,
    input  wire logic drv_oe_b_i,
    // Outside party pulling the pin low.
    input  wire logic pull_low_i,
    // Resolved pin level.
    output logic      level_o
);
    // The pull-up wins only when nobody drives the wire low.
    assign level_o = ((!drv_oe_b_i && !drv_i) || pull_low_i) ? 1'b0 : 1'b1;
endmodule : rst_pin_model

// >>> dv/sys_seq_monitor.sv
// Port-level assertion checker for the clock and reset sequencer.
`timescale 1ns/1ps
module sys_seq_monitor (
    // Clock, power-on reset and bus strobes.
    input wire logic       REF_CLK_I, RST_B_I, PSEL_I, PENABLE_I,
    input wire logic [7:0] PADDR_I,
    // Status and event inputs.
    input wire logic       BAD_OPCODE_I, OPCODE_FETCH_I, UNMAPPED_ADDR_I,
    // Watched outputs.
    input wire logic       PREADY_O, PSLVERR_O, RST_PIN_OE_B_O, BUS_CLK_EN_O,
    input wire logic       CPU_CLK_EN_O, PERIPH_CLK_EN_O, OSC_EN_O, INTERNAL_RESET_O
);
    // Everything here belongs to the one clock domain.
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);

    // Bus enable pulses are four 4x cycles apart, never closer.
    a_bus_div_four: assert property (BUS_CLK_EN_O |=> !BUS_CLK_EN_O [*3])
        else $error("bus enable pulses too close");
    a_cpu_clk_gate: assert property (CPU_CLK_EN_O |-> BUS_CLK_EN_O && !INTERNAL_RESET_O)
        else $error("cpu clock gated wrongly");
    a_periph_in_rst: assert property (PERIPH_CLK_EN_O |-> !INTERNAL_RESET_O)
        else $error("peripheral clock in reset");
    a_stop_clk_off: assert property (!OSC_EN_O |-> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
        else $error("clocks run in stop");
    a_bad_op_rst: assert property (BAD_OPCODE_I && !INTERNAL_RESET_O |=> INTERNAL_RESET_O)
        else $error("bad opcode gave no reset");
    a_bad_fetch_rst: assert property (OPCODE_FETCH_I && UNMAPPED_ADDR_I && !INTERNAL_RESET_O
        |=> INTERNAL_RESET_O)
        else $error("unmapped fetch gave no reset");
    // A pin drive lasts at least 32 cycles; the reset then outlasts it by 35 more.
    a_pin_low_span: assert property ($fell(RST_PIN_OE_B_O) |-> ##31 !RST_PIN_OE_B_O)
        else $error("pin released early");
    a_tail_hold: assert property ($rose(RST_PIN_OE_B_O) |-> INTERNAL_RESET_O ##34 INTERNAL_RESET_O)
        else $error("internal reset ended early");
    a_apb_err_map: assert property (PSEL_I && PENABLE_I && PADDR_I > 8'h10 |-> PSLVERR_O && PREADY_O)
        else $error("unmapped access without error");

    // Main scenarios reached.
    c_bad_op: cover property (BAD_OPCODE_I && !INTERNAL_RESET_O);
    c_stop: cover property ($fell(OSC_EN_O));
    c_pin: cover property ($fell(RST_PIN_OE_B_O));
endmodule : sys_seq_monitor

bind system_clock_reset_sequencer sys_seq_monitor u_mon (.*);

// >>> dv/system_clock_reset_sequencer_tb.sv
// Self-checking bench for the clock and reset sequencer.
`timescale 1ns/1ps
module system_clock_reset_sequencer_tb;
    logic        clk, rst_b, psel, pen, pwr, uv, pull, er, pin, pin_o, oe_b, gpio, brk;
    logic        pready, pslverr, bus_en, cpu_en, per_en, osc_en, internal_reset;
    logic [5:0]  ev;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          bad_count, n_tests, hi, lo, k, c1, c2;

    // Watchdog shortened to two bits so an overflow fits in the run.
    system_clock_reset_sequencer #(.WDOG_W(2), .MIN_PULSE_NS(100)) dut (
        .REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .WAIT_INSN_I(ev[0]), .STOP_INSN_I(ev[1]), .WAKE_I(ev[2]),
        .BAD_OPCODE_I(ev[3]), .OPCODE_FETCH_I(ev[4]), .UNMAPPED_ADDR_I(ev[5]),
        .BREAK_ACTIVE_I(brk), .MONITOR_MODE_I(brk), .UNDERVOLT_I(uv), .RST_PIN_I(pin),
        .RST_PIN_O(pin_o), .RST_PIN_OE_B_O(oe_b), .PIN_GPIO_O(gpio), .BUS_CLK_EN_O(bus_en),
        .CPU_CLK_EN_O(cpu_en), .PERIPH_CLK_EN_O(per_en), .OSC_EN_O(osc_en),
        .INTERNAL_RESET_O(internal_reset));
    rst_pin_model u_pin (.drv_i(pin_o), .drv_oe_b_i(oe_b), .pull_low_i(pull), .level_o(pin));

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    // One APB transfer; held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        if (k >= 50) begin chk(0, 1, "bus answer timeout"); results(); end
    endtask : apb

    task automatic cause(input logic [31:0] exp);
        apb(1'b0, clk_rst_seq_pkg::CAUSE_OFF, 32'h0);
        chk(rd, exp, "reset cause value");
    endtask : cause

    // Counts reset and pin-drive cycles until the internal reset ends.
    task automatic seq(input int lim);
        hi = 0; lo = 0;
        for (k = 0; k < lim; k++) begin
            #1;
            if (internal_reset === 1'b1) hi++;
            if (oe_b === 1'b0) lo++;
            if (hi > 0 && internal_reset === 1'b0) break;
            @(posedge clk);
        end
        if (k == lim) begin chk(0, 1, "reset sequence timeout"); results(); end
    endtask : seq

    // Pulses one cycle of events, then checks a 67-cycle internal reset.
    task automatic rst_case(input logic [5:0] m, input int bit_no);
        @(posedge clk); ev <= m;
        @(posedge clk); ev <= 6'h00;
        seq(300);
        chk(hi, 67, "internal reset length");
        chk(lo, 32, "pin drive length");
        cause(32'h1 << bit_no);
    endtask : rst_case

    initial begin
        rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        ev = 6'h00; uv = 1'b0; pull = 1'b0; bad_count = 0; n_tests = 0; brk = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        seq(5000);
        chk(hi > 4159 && hi < 4176, 1, "power-on recovery length");
        chk(lo, 0, "pin driven, function off");
        chk(gpio, 1'b1, "pin input level");
        cause(32'h01);
        apb(1'b1, clk_rst_seq_pkg::OPT_TWO_OFF, 32'h1);
        rst_case(6'h02, clk_rst_seq_pkg::CAUSE_BADOP);
        rst_case(6'h08, clk_rst_seq_pkg::CAUSE_BADOP);
        @(posedge clk); ev <= 6'h20;
        @(posedge clk); ev <= 6'h00;
        repeat (4) @(posedge clk);
        chk(internal_reset, 1'b0, "data fetch reset");
        rst_case(6'h30, clk_rst_seq_pkg::CAUSE_BADADR);
        // Outside party holds the pin low for six cycles.
        @(posedge clk); pull <= 1'b1;
        repeat (6) @(posedge clk);
        pull <= 1'b0;
        seq(300);
        chk(lo, 32, "pin drive, pin reset");
        cause(32'h02);
        // Wait mode: peripherals keep their pulses, the CPU gets none.
        apb(1'b1, clk_rst_seq_pkg::OPT_ONE_OFF, 32'h3);
        @(posedge clk); ev <= 6'h01;
        @(posedge clk); ev <= 6'h00;
        repeat (2) @(posedge clk);
        c1 = 0; c2 = 0;
        repeat (8) begin
            @(posedge clk); #1;
            c1 += (cpu_en === 1'b1);
            c2 += (per_en === 1'b1);
        end
        chk(c1, 0, "cpu clock in wait");
        chk(c2, 2, "peripheral clock in wait");
        @(posedge clk); ev <= 6'h04;
        @(posedge clk); ev <= 6'h02;
        @(posedge clk); ev <= 6'h00;
        repeat (2) @(posedge clk);
        chk(osc_en, 1'b0, "oscillator on in stop");
        @(posedge clk); ev <= 6'h04;
        @(posedge clk); ev <= 6'h00;
        for (k = 0; k < 200 && cpu_en !== 1'b1; k++) @(posedge clk);
        chk(k > 30 && k < 48, 1, "short wake delay");
        // Break in monitor mode stops the watchdog.
        apb(1'b1, clk_rst_seq_pkg::BRK_AUX_OFF, 32'h1);
        brk <= 1'b1;
        repeat (17000) @(posedge clk);
        chk(internal_reset, 1'b0, "watchdog ran in break");
        brk <= 1'b0;
        // Regular service keeps the watchdog quiet past four ticks.
        repeat (6) begin
            repeat (3000) @(posedge clk);
            apb(1'b1, clk_rst_seq_pkg::WDOG_SVC_OFF, 32'hA5);
        end
        chk(internal_reset, 1'b0, "watchdog fired");
        cause(32'h00);
        seq(20000);
        chk(hi, 67, "watchdog reset length");
        cause(32'h04);
        @(posedge clk); uv <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(oe_b, 1'b0, "pin not held in undervoltage");
        @(posedge clk); uv <= 1'b0;
        seq(5000);
        chk(hi > 4159, 1, "undervoltage recovery length");
        cause(32'h20);
        apb(1'b0, 8'h20, 32'h0);
        chk(er, 1'b1, "unmapped access error");
        chk(rd, 32'h0, "unmapped read data");
        results();
    end
endmodule : system_clock_reset_sequencer_tb

// >>> logic/clk_rst_seq_pkg.sv
// Constants, register map and state type for the clock and reset sequencer.
package clk_rst_seq_pkg;

    // Stabilisation counter shape and delays, in cycles of the 4x clock.
    localparam int unsigned STAB_STAGES   = 13;
    localparam int unsigned LONG_DELAY    = 4096;
    localparam int unsigned SHORT_DELAY   = 32;
    localparam int unsigned SHORT_BIT     = 5;
    localparam int unsigned MID_CLR_LO    = 4;
    localparam int unsigned MID_CLR_HI    = 11;
    localparam int unsigned PIN_LOW_CYC   = 32;
    localparam int unsigned TAIL_CYC      = 32;
    localparam int unsigned RECOVER_CYC   = 3;
    localparam int unsigned BUS_DIV       = 4;
    localparam int unsigned CLK_MHZ       = 10;

    // Register byte offsets.
    localparam logic [7:0] CAUSE_OFF      = 8'h00;
    localparam logic [7:0] OPT_ONE_OFF    = 8'h04;
    localparam logic [7:0] OPT_TWO_OFF    = 8'h08;
    localparam logic [7:0] BRK_AUX_OFF    = 8'h0C;
    localparam logic [7:0] WDOG_SVC_OFF   = 8'h10;

    // Reset cause register field positions.
    localparam int unsigned CAUSE_POR     = 0;
    localparam int unsigned CAUSE_PIN     = 1;
    localparam int unsigned CAUSE_WDOG    = 2;
    localparam int unsigned CAUSE_BADOP   = 3;
    localparam int unsigned CAUSE_BADADR  = 4;
    localparam int unsigned CAUSE_UNDERV  = 5;
    localparam int unsigned CAUSE_W       = 6;
    localparam logic [5:0]  CAUSE_RESET   = 6'h01;

    // Option and break register field positions.
    localparam int unsigned OPT1_SHORT    = 0;
    localparam int unsigned OPT1_STOPEN   = 1;
    localparam int unsigned OPT2_RESET_FUNCTION_ENABLE    = 0;
    localparam int unsigned BRK_WDDIS     = 0;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_STAB,
        ST_UV_HOLD,
        ST_PIN_LOW,
        ST_TAIL,
        ST_RECOVER,
        ST_EXT_HOLD
    } seq_state_t;

endpackage : clk_rst_seq_pkg

// >>> logic/stab_counter.sv
// Thirteen-stage stabilisation counter advancing on the falling clock edge.
`timescale 1ns/1ps
module stab_counter #(
    parameter int unsigned STAGES = clk_rst_seq_pkg::STAB_STAGES
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // Clear requests from the sequencer.
    input  wire logic              clr_all_i,
    input  wire logic              clr_mid_i,
    // Count and watchdog tick.
    output logic [STAGES-1:0]      count_o,
    output logic                   tick_o
);

    logic [STAGES-1:0] cnt_r;
    logic [STAGES-1:0] cnt_nxt;

    // The top stage restarts the chain, so it is high for exactly one cycle.
    always_comb begin
        cnt_nxt = cnt_r + {{(STAGES-1){1'b0}}, 1'b1};
        if (cnt_r[STAGES-1]) begin
            cnt_nxt = '0;
        end
        if (clr_mid_i) begin
            cnt_nxt[clk_rst_seq_pkg::MID_CLR_HI:clk_rst_seq_pkg::MID_CLR_LO] = '0;
        end
        if (clr_all_i) begin
            cnt_nxt = '0;
        end
    end

    // Falling edge gives the sequencer half a cycle of settling on each count.
    always_ff @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign count_o = cnt_r;
    assign tick_o  = cnt_r[STAGES-1];

endmodule : stab_counter

// >>> logic/system_clock_reset_sequencer.sv
// Bus clock gating, reset source collection and reset sequencing with an APB slave.
//
// Overview of operation
// - Bus clock enable is the 4x clock divided by four.
// - Bus clocks stay off through the power-on delay.
// - Stop exit clocks stabilisation counter, clocks wait.
// - Wait mode stops CPU clocks, peripherals keep clocking.
// - Every reset source asserts the internal reset.
// - Internal resets clear the counter; pin resets do not.
// - Each reset source sets its own cause flag.
// - Pin low halts; long pulses set pin flag.
// - Pin is plain input until reset function enabled.
// - Internal resets drive pin 32, then hold reset 35 more.
// - Recovery is 4163 or 67 cycles in total.
// - Power-on counts 4096, releases 67 later, flags.
// - Watchdog overflow resets and sets its flag.
// - Service write clears watchdog and middle stages.
// - Counter top stage clocks the watchdog counter.
// - Break in monitor mode may disable watchdog.
// - Bad opcode, or disabled stop, resets and flags.
// - Unmapped opcode fetch resets; data fetch does not.
// - Undervoltage flags, holds pin, counts after recovery.
// - Twelve counting stages plus a restarting top stage.
// - Stabilisation counter advances on falling edge.
// - Stop clears counter; short bit gives 32 cycles.
`timescale 1ns/1ps
module system_clock_reset_sequencer #(
    parameter int unsigned WDOG_W       = 6,
    parameter int unsigned MIN_PULSE_NS = 100
) (
    // Clock and power-on reset.
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_B_I,
    // APB slave.
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // CPU status and reset sources.
    input  wire logic        WAIT_INSN_I,
    input  wire logic        STOP_INSN_I,
    input  wire logic        WAKE_I,
    input  wire logic        BAD_OPCODE_I,
    input  wire logic        OPCODE_FETCH_I,
    input  wire logic        UNMAPPED_ADDR_I,
    input  wire logic        BREAK_ACTIVE_I,
    input  wire logic        MONITOR_MODE_I,
    input  wire logic        UNDERVOLT_I,
    // Reset pin.
    input  wire logic        RST_PIN_I,
    output logic             RST_PIN_O,
    output logic             RST_PIN_OE_B_O,
    output logic             PIN_GPIO_O,
    // Clock enables, oscillator and internal reset.
    output logic             BUS_CLK_EN_O,
    output logic             CPU_CLK_EN_O,
    output logic             PERIPH_CLK_EN_O,
    output logic             OSC_EN_O,
    output logic             INTERNAL_RESET_O
);

    localparam int unsigned MIN_PULSE_CYC_RAW =
        (MIN_PULSE_NS * clk_rst_seq_pkg::CLK_MHZ + 999) / 1000;
    localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_CYC_RAW < 1) ? 1 : MIN_PULSE_CYC_RAW;
    localparam logic [15:0] MIN_PULSE_W   = 16'(MIN_PULSE_CYC);
    localparam logic [6:0]  PIN_LOW_LAST  = 7'(clk_rst_seq_pkg::PIN_LOW_CYC - 1);
    localparam logic [6:0]  TAIL_LAST     = 7'(clk_rst_seq_pkg::TAIL_CYC - 1);
    localparam logic [6:0]  RECOVER_LAST  = 7'(clk_rst_seq_pkg::RECOVER_CYC - 1);
    localparam logic [1:0]  DIV_LAST      = 2'(clk_rst_seq_pkg::BUS_DIV - 1);

    // Two-flop synchronisers for the pin and the undervoltage detector.
    logic [1:0] pin_sync_r;
    logic [1:0] uv_sync_r;

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_sync_r <= 2'h3;
            uv_sync_r  <= 2'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], RST_PIN_I};
            uv_sync_r  <= {uv_sync_r[0], UNDERVOLT_I};
        end
    end

    logic pin_lvl;
    logic uv_lvl;
    assign pin_lvl = pin_sync_r[1];
    assign uv_lvl  = uv_sync_r[1];

    // Register and sequencer state.
    clk_rst_seq_pkg::seq_state_t state_r, state_nxt;
    logic [6:0]                  seq_cnt_r, seq_cnt_nxt;
    logic                        from_rst_r, from_rst_nxt;
    logic                        short_r, short_nxt;
    logic [15:0]                 pulse_cnt_r, pulse_cnt_nxt;
    logic [1:0]                  div_r, div_nxt;
    logic [WDOG_W-1:0]           wdog_r, wdog_nxt;
    logic [5:0]                  cause_r, cause_nxt;
    logic [1:0]                  opt_one_r, opt_one_nxt;
    logic                        opt_two_r, opt_two_nxt;
    logic                        brk_aux_r, brk_aux_nxt;
    logic [31:0]                 prdata_r, prdata_nxt;

    // Stabilisation counter and its clear requests.
    logic [clk_rst_seq_pkg::STAB_STAGES-1:0] stab_cnt;
    logic                                    stab_tick;
    logic                                    clr_all;
    logic                                    clr_mid;

    stab_counter #(
        .STAGES   (clk_rst_seq_pkg::STAB_STAGES)
    ) u_stab (
        .clk_i    (REF_CLK_I),
        .rst_b_i  (RST_B_I),
        .clr_all_i(clr_all),
        .clr_mid_i(clr_mid),
        .count_o  (stab_cnt),
        .tick_o   (stab_tick)
    );

    // APB decode; the slave answers in the first access cycle.
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    assign acc    = PSEL_I && PENABLE_I;
    assign wr     = acc && PWRITE_I;
    assign rd     = acc && !PWRITE_I;
    assign mapped = (PADDR_I == clk_rst_seq_pkg::CAUSE_OFF)   ||
                    (PADDR_I == clk_rst_seq_pkg::OPT_ONE_OFF) ||
                    (PADDR_I == clk_rst_seq_pkg::OPT_TWO_OFF) ||
                    (PADDR_I == clk_rst_seq_pkg::BRK_AUX_OFF) ||
                    (PADDR_I == clk_rst_seq_pkg::WDOG_SVC_OFF);

    logic svc_wr;
    assign svc_wr = wr && (PADDR_I == clk_rst_seq_pkg::WDOG_SVC_OFF);

    // Reset source decode.
    logic in_reset;
    logic wd_enable;
    logic wd_over;
    logic ev_badop;
    logic ev_badadr;
    logic ev_pin;
    logic rst_fn_en;

    assign rst_fn_en = opt_two_r;
    assign in_reset  = (state_r == clk_rst_seq_pkg::ST_UV_HOLD)  ||
                       (state_r == clk_rst_seq_pkg::ST_PIN_LOW)  ||
                       (state_r == clk_rst_seq_pkg::ST_TAIL)     ||
                       (state_r == clk_rst_seq_pkg::ST_RECOVER)  ||
                       (state_r == clk_rst_seq_pkg::ST_EXT_HOLD) ||
                       ((state_r == clk_rst_seq_pkg::ST_STAB) && from_rst_r);
    assign wd_enable = !(BREAK_ACTIVE_I && MONITOR_MODE_I && brk_aux_r) && !in_reset;
    assign wd_over   = wd_enable && stab_tick && (&wdog_r);
    assign ev_badop  = BAD_OPCODE_I ||
                       (STOP_INSN_I && !opt_one_r[clk_rst_seq_pkg::OPT1_STOPEN]);
    assign ev_badadr = OPCODE_FETCH_I && UNMAPPED_ADDR_I;
    assign ev_pin    = rst_fn_en && !pin_lvl;

    // Free-running divide-by-four for the bus clock enable.
    always_comb begin
        div_nxt = div_r + 2'h1;
        if (div_r == DIV_LAST) begin
            div_nxt = 2'h0;
        end
    end

    // Watchdog counter is clocked by the stabilisation counter top stage.
    always_comb begin
        wdog_nxt = wdog_r;
        if (svc_wr || in_reset || !wd_enable) begin
            wdog_nxt = '0;
        end else if (stab_tick) begin
            wdog_nxt = wdog_r + {{(WDOG_W-1){1'b0}}, 1'b1};
        end
    end

    // Sequencer: reset sources, delays and low-power modes.
    always_comb begin
        state_nxt     = state_r;
        seq_cnt_nxt   = seq_cnt_r + 7'h01;
        from_rst_nxt  = from_rst_r;
        short_nxt     = short_r;
        pulse_cnt_nxt = pulse_cnt_r;
        cause_nxt     = cause_r;
        clr_all       = 1'b0;
        clr_mid       = svc_wr;
        // Reading the cause register clears it; a new cause below still wins.
        if (rd && (PADDR_I == clk_rst_seq_pkg::CAUSE_OFF)) begin
            cause_nxt = '0;
        end
        if (uv_lvl && (state_r != clk_rst_seq_pkg::ST_UV_HOLD)) begin
            state_nxt = clk_rst_seq_pkg::ST_UV_HOLD;
            cause_nxt = 6'h01 << clk_rst_seq_pkg::CAUSE_UNDERV;
            clr_all   = 1'b1;
        end else if (!in_reset && (wd_over || ev_badop || ev_badadr)) begin
            state_nxt   = clk_rst_seq_pkg::ST_PIN_LOW;
            seq_cnt_nxt = 7'h00;
            clr_all     = 1'b1;
            if (wd_over) begin
                cause_nxt = 6'h01 << clk_rst_seq_pkg::CAUSE_WDOG;
            end else if (ev_badop) begin
                cause_nxt = 6'h01 << clk_rst_seq_pkg::CAUSE_BADOP;
            end else begin
                cause_nxt = 6'h01 << clk_rst_seq_pkg::CAUSE_BADADR;
            end
        end else if (!in_reset && ev_pin) begin
            state_nxt     = clk_rst_seq_pkg::ST_EXT_HOLD;
            pulse_cnt_nxt = 16'h0001;
        end else begin
            unique case (state_r)
                clk_rst_seq_pkg::ST_RUN: begin
                    if (STOP_INSN_I) begin
                        state_nxt = clk_rst_seq_pkg::ST_STOP;
                        clr_all   = 1'b1;
                    end else if (WAIT_INSN_I) begin
                        state_nxt = clk_rst_seq_pkg::ST_WAIT;
                    end
                end
                clk_rst_seq_pkg::ST_WAIT: begin
                    if (WAKE_I) begin
                        state_nxt = clk_rst_seq_pkg::ST_RUN;
                    end
                end
                clk_rst_seq_pkg::ST_STOP: begin
                    clr_all = 1'b1;
                    if (WAKE_I) begin
                        state_nxt    = clk_rst_seq_pkg::ST_STAB;
                        from_rst_nxt = 1'b0;
                        short_nxt    = opt_one_r[clk_rst_seq_pkg::OPT1_SHORT];
                    end
                end
                clk_rst_seq_pkg::ST_UV_HOLD: begin
                    clr_all = 1'b1;
                    if (!uv_lvl) begin
                        state_nxt    = clk_rst_seq_pkg::ST_STAB;
                        from_rst_nxt = 1'b1;
                        short_nxt    = 1'b0;
                    end
                end
                clk_rst_seq_pkg::ST_STAB: begin
                    // Top stage marks 4096 counts; bit five marks 32.
                    if (short_r ? stab_cnt[clk_rst_seq_pkg::SHORT_BIT] : stab_tick) begin
                        seq_cnt_nxt = 7'h00;
                        state_nxt   = from_rst_r ? clk_rst_seq_pkg::ST_PIN_LOW
                                                 : clk_rst_seq_pkg::ST_RUN;
                        from_rst_nxt = 1'b0;
                    end
                end
                clk_rst_seq_pkg::ST_PIN_LOW: begin
                    if (seq_cnt_r == PIN_LOW_LAST) begin
                        seq_cnt_nxt = 7'h00;
                        state_nxt   = clk_rst_seq_pkg::ST_TAIL;
                    end
                end
                clk_rst_seq_pkg::ST_TAIL: begin
                    if (seq_cnt_r == TAIL_LAST) begin
                        seq_cnt_nxt = 7'h00;
                        state_nxt   = clk_rst_seq_pkg::ST_RECOVER;
                    end
                end
                clk_rst_seq_pkg::ST_RECOVER: begin
                    if (seq_cnt_r == RECOVER_LAST) begin
                        state_nxt = clk_rst_seq_pkg::ST_RUN;
                    end
                end
                clk_rst_seq_pkg::ST_EXT_HOLD: begin
                    // The counter is left alone so the oscillator stays settled.
                    if (pulse_cnt_r != 16'hFFFF) begin
                        pulse_cnt_nxt = pulse_cnt_r + 16'h0001;
                    end
                    if (pin_lvl) begin
                        seq_cnt_nxt = 7'h00;
                        state_nxt   = clk_rst_seq_pkg::ST_PIN_LOW;
                        if (pulse_cnt_r >= MIN_PULSE_W) begin
                            cause_nxt = 6'h01 << clk_rst_seq_pkg::CAUSE_PIN;
                        end
                    end
                end
            endcase
        end
    end

    // Register writes; options survive internal resets and clear only at power-on.
    always_comb begin
        opt_one_nxt = opt_one_r;
        opt_two_nxt = opt_two_r;
        brk_aux_nxt = brk_aux_r;
        prdata_nxt  = prdata_r;
        if (wr && !in_reset) begin
            if (PADDR_I == clk_rst_seq_pkg::OPT_ONE_OFF) begin
                opt_one_nxt = PWDATA_I[1:0];
            end
            if (PADDR_I == clk_rst_seq_pkg::OPT_TWO_OFF) begin
                opt_two_nxt = PWDATA_I[clk_rst_seq_pkg::OPT2_RESET_FUNCTION_ENABLE];
            end
            if (PADDR_I == clk_rst_seq_pkg::BRK_AUX_OFF) begin
                brk_aux_nxt = PWDATA_I[clk_rst_seq_pkg::BRK_WDDIS];
            end
        end
        if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            unique case (PADDR_I)
                clk_rst_seq_pkg::CAUSE_OFF:   prdata_nxt = {26'h0, cause_r};
                clk_rst_seq_pkg::OPT_ONE_OFF: prdata_nxt = {30'h0, opt_one_r};
                clk_rst_seq_pkg::OPT_TWO_OFF: prdata_nxt = {31'h0, opt_two_r};
                clk_rst_seq_pkg::BRK_AUX_OFF: prdata_nxt = {31'h0, brk_aux_r};
                default:                      prdata_nxt = 32'h0;
            endcase
        end
    end

    // State registers; power-on starts the long delay with reset asserted.
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_r     <= clk_rst_seq_pkg::ST_STAB;
            seq_cnt_r   <= 7'h00;
            from_rst_r  <= 1'b1;
            short_r     <= 1'b0;
            pulse_cnt_r <= 16'h0000;
            div_r       <= 2'h0;
            wdog_r      <= '0;
            cause_r     <= clk_rst_seq_pkg::CAUSE_RESET;
            opt_one_r   <= 2'h0;
            opt_two_r   <= 1'b0;
            brk_aux_r   <= 1'b0;
            prdata_r    <= 32'h0;
        end else begin
            state_r     <= state_nxt;
            seq_cnt_r   <= seq_cnt_nxt;
            from_rst_r  <= from_rst_nxt;
            short_r     <= short_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            div_r       <= div_nxt;
            wdog_r      <= wdog_nxt;
            cause_r     <= cause_nxt;
            opt_one_r   <= opt_one_nxt;
            opt_two_r   <= opt_two_nxt;
            brk_aux_r   <= brk_aux_nxt;
            prdata_r    <= prdata_nxt;
        end
    end

    // Bus answer, zero wait states; unmapped addresses report an error.
    assign PRDATA_O  = prdata_r;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = acc && !mapped;

    // Clock enables gated by state; wait keeps peripherals running.
    logic bus_tick;
    assign bus_tick         = (div_r == DIV_LAST);
    assign BUS_CLK_EN_O     = bus_tick && !in_reset && (state_r != clk_rst_seq_pkg::ST_STOP)
                              && (state_r != clk_rst_seq_pkg::ST_STAB);
    assign CPU_CLK_EN_O     = bus_tick && (state_r == clk_rst_seq_pkg::ST_RUN);
    assign PERIPH_CLK_EN_O  = bus_tick && ((state_r == clk_rst_seq_pkg::ST_RUN) ||
                              (state_r == clk_rst_seq_pkg::ST_WAIT));
    assign OSC_EN_O         = (state_r != clk_rst_seq_pkg::ST_STOP);
    assign INTERNAL_RESET_O = in_reset;

    // Pin drive: low during internal reset phases, only with the reset function on.
    logic drive_low;
    assign drive_low      = rst_fn_en && ((state_r == clk_rst_seq_pkg::ST_PIN_LOW) ||
                            (state_r == clk_rst_seq_pkg::ST_UV_HOLD) ||
                            ((state_r == clk_rst_seq_pkg::ST_STAB) && from_rst_r));
    assign RST_PIN_O      = 1'b0;
    assign RST_PIN_OE_B_O = !drive_low;
    assign PIN_GPIO_O     = pin_lvl;

endmodule : system_clock_reset_sequencer
